// file: common/crst_pkg.sv
// shared constants, types and tables of the register self-test sequencer
package crst_pkg;

  // alternating test patterns
  localparam logic [31:0] PAT_A = 32'h5555_5555;
  localparam logic [31:0] PAT_B = 32'hAAAA_AAAA;
  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // sequence geometry
  localparam int NUM_GPR = 16;
  localparam logic [3:0] PAIR_LAST_STEP = 4'hB;
  localparam logic [5:0] COUPLE_LAST_STEP = 6'h3F;
  localparam logic [3:0] SCRATCH_LAST_UNIT = 4'h3;
  localparam logic [3:0] PRESERVED_LAST_UNIT = 4'h4;
  localparam logic [3:0] CTRL_LAST_UNIT = 4'h7;
  localparam int ACC_LOW_BITS = 16;

  // control register indices on the core port
  localparam logic [3:0] CTRL_INTERRUPT_STACK_POINTER = 4'h0;
  localparam logic [3:0] CTRL_USER_STACK_POINTER = 4'h1;
  localparam logic [3:0] CTRL_INTERRUPT_TABLE_BASE = 4'h2;
  localparam logic [3:0] CTRL_PROCESSOR_STATUS_WORD = 4'h3;
  localparam logic [3:0] CTRL_BACKUP_PROGRAM_COUNTER = 4'h4;
  localparam logic [3:0] CTRL_BACKUP_STATUS_WORD = 4'h5;
  localparam logic [3:0] CTRL_FAST_INTERRUPT_VECTOR = 4'h6;
  localparam logic [3:0] CTRL_FLOAT_STATUS_WORD = 4'h7;

  // writable-bit masks per control register, indexed as above
  localparam logic [31:0] CTRL_MASK [8] = '{
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF
  };

  // kind of access made on the core port
  typedef enum logic [2:0] {
    K_GPR = 3'b000,
    K_CTRL = 3'b001,
    K_ACC_HI = 3'b010,
    K_ACC_LO = 3'b011,
    K_ACC_MID = 3'b100,
    K_CALL = 3'b101
  } crst_kind_t;

  // test phases in run order
  typedef enum logic [2:0] {
    PH_GPR1 = 3'b000,
    PH_GPR2 = 3'b001,
    PH_CTRL = 3'b010,
    PH_ACC = 3'b011,
    PH_PC = 3'b100
  } crst_phase_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CHECK = 3'b011,
    ST_DONE = 3'b100,
    ST_FAIL = 3'b101
  } crst_state_t;

  // request towards the core, held until acknowledged
  typedef struct packed {
    logic valid;
    crst_kind_t kind;
    logic write;
    logic [3:0] index;
    logic [31:0] data;
  } crst_req_t;

  // answer from the core, one-cycle pulse
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } crst_rsp_t;

  // one step of the test sequence
  typedef struct packed {
    crst_kind_t kind;
    logic write;
    logic save;
    logic cmp;
    logic restore;
    logic [3:0] slot;
    logic [3:0] index;
    logic [31:0] data;
    logic [31:0] exp_val;
    logic [31:0] mask;
  } crst_op_t;

  // register of a pair: group one 1..5,14,15; group two 0,6..13
  function automatic logic [3:0] crst_pair_reg(input logic second_group,
                                               input logic [3:0] unit,
                                               input logic which);
    logic [3:0] pos;
    pos = {unit[2:0], which};
    if (!second_group) begin
      case (pos)
        4'h0: crst_pair_reg = 4'h1;
        4'h1: crst_pair_reg = 4'h2;
        4'h2: crst_pair_reg = 4'h3;
        4'h3: crst_pair_reg = 4'h4;
        4'h4: crst_pair_reg = 4'h5;
        4'h5: crst_pair_reg = 4'hE;
        4'h6: crst_pair_reg = 4'hF;
        default: crst_pair_reg = 4'h1;
      endcase
    end else begin
      case (pos)
        4'h0: crst_pair_reg = 4'h0;
        4'h1: crst_pair_reg = 4'h6;
        4'h2: crst_pair_reg = 4'h7;
        4'h3: crst_pair_reg = 4'h8;
        4'h4: crst_pair_reg = 4'h9;
        4'h5: crst_pair_reg = 4'hA;
        4'h6: crst_pair_reg = 4'hB;
        4'h7: crst_pair_reg = 4'hC;
        4'h8: crst_pair_reg = 4'hD;
        default: crst_pair_reg = 4'h0;
      endcase
    end
  endfunction : crst_pair_reg

endpackage : crst_pkg

// file: hdl/crst_checker.sv
// masked compare of a read-back word against its expected value
`timescale 1ns/1ps
module crst_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  // compare request
  input wire logic i_valid,
  input wire logic [31:0] i_data,
  input wire logic [31:0] i_exp,
  input wire logic [31:0] i_mask,
  // result, one cycle after the request
  output logic o_fail
);
  import crst_pkg::*;

  // only bits under the mask take part in the compare
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fail <= 1'b0;
    end else if (i_en) begin
      o_fail <= i_valid && ((i_data & i_mask) != (i_exp & i_mask));
    end
  end

endmodule : crst_checker

// file: hdl/crst_step_gen.sv
// decodes phase, unit and step into one core access of the sequence
`timescale 1ns/1ps
module crst_step_gen #(
  parameter bit COUPLING = 1'b0
) (
  // position in the sequence
  input wire crst_pkg::crst_phase_t i_phase,
  input wire logic [3:0] i_unit,
  input wire logic [5:0] i_step,
  // decoded access
  output crst_pkg::crst_op_t o_op,
  output logic o_last_step,
  output logic o_last_unit
);
  import crst_pkg::*;

  logic [2:0] grp;
  logic which;
  logic [31:0] pat;
  logic [31:0] msk;
  logic odd;

  // pair template: save, write A, check A, write B, check B, restore
  always_comb begin
    o_op = '0;
    o_op.mask = ALL_ONES;
    o_last_step = 1'b0;
    o_last_unit = 1'b0;
    grp = i_step[3:1];
    which = i_step[0];
    pat = (grp < 3'd3) ? PAT_A : PAT_B;
    msk = ALL_ONES;
    odd = 1'b0;
    if (i_phase == PH_PC) begin
      // distant call returns the inverse of its parameter
      o_op.kind = K_CALL;
      o_op.write = 1'b1;
      o_op.cmp = 1'b1;
      o_op.data = PAT_A;
      o_op.exp_val = ~PAT_A;
      o_last_step = 1'b1;
      o_last_unit = 1'b1;
    end else if (COUPLING && (i_phase == PH_GPR1 || i_phase == PH_GPR2)) begin
      // all sixteen written before any is read back
      odd = i_step[0] ^ (i_phase == PH_GPR2);
      pat = odd ? PAT_B : PAT_A;
      o_op.kind = K_GPR;
      o_op.index = i_step[3:0];
      o_op.slot = i_step[3:0];
      case (i_step[5:4])
        2'b00: o_op.save = 1'b1;
        2'b01: begin
          o_op.write = 1'b1;
          o_op.data = pat;
        end
        2'b10: begin
          o_op.cmp = 1'b1;
          o_op.exp_val = pat;
        end
        default: begin
          o_op.write = 1'b1;
          o_op.restore = 1'b1;
        end
      endcase
      o_last_step = (i_step == COUPLE_LAST_STEP);
      o_last_unit = 1'b1;
    end else begin
      o_op.slot = {3'b000, which};
      if (i_phase == PH_CTRL) begin
        msk = CTRL_MASK[i_unit[2:0]];
      end
      case (grp)
        3'd0: o_op.save = 1'b1;
        3'd1, 3'd3: begin
          o_op.write = 1'b1;
          o_op.data = pat & msk;
        end
        3'd2, 3'd4: begin
          o_op.cmp = 1'b1;
          o_op.exp_val = pat & msk;
        end
        default: begin
          o_op.write = 1'b1;
          o_op.restore = 1'b1;
        end
      endcase
      o_op.mask = msk;
      case (i_phase)
        PH_GPR1: begin
          o_op.kind = K_GPR;
          o_op.index = crst_pair_reg(1'b0, i_unit, which);
          o_last_unit = (i_unit == SCRATCH_LAST_UNIT);
        end
        PH_GPR2: begin
          o_op.kind = K_GPR;
          o_op.index = crst_pair_reg(1'b1, i_unit, which);
          o_last_unit = (i_unit == PRESERVED_LAST_UNIT);
        end
        PH_CTRL: begin
          o_op.kind = K_CTRL;
          o_op.index = i_unit;
          o_last_unit = (i_unit == CTRL_LAST_UNIT);
        end
        default: begin
          // low half is only written; reads use high and bits 47..16
          if (!which) begin
            o_op.kind = K_ACC_HI;
          end else if (o_op.write) begin
            o_op.kind = K_ACC_LO;
          end else begin
            o_op.kind = K_ACC_MID;
          end
          o_last_unit = 1'b1;
        end
      endcase
      o_last_step = (i_step[3:0] == PAIR_LAST_STEP);
    end
  end

endmodule : crst_step_gen

// file: hdl/crst_reg_self_test.sv
// sequencer that exercises a processor register set and traps on mismatch
// notes for users of the block:
// the core port carries one request at a time; valid stands until
// the core acknowledges it, so a slow core only stretches the run.
// every compare step (not the save reads) goes through one extra check cycle, so
// a mismatch is known before the next request is issued.
// pair groups with an odd register count pair the last one with the
// first again, which keeps the step decoder uniform.
// the control phase leans on the scratch registers of the first group,
// so it is held off until both general phases have finished cleanly.
// saved contents live in sixteen slots; the pair phases use two of
// them, the coupling variant all sixteen.
// after a mismatch only reset leaves the fail state; a new start is
// ignored, since the register file can no longer be trusted.
// the clock enable freezes the sequencer and its compare stage alike;
// the core must not answer while the enable is low, or the answer is lost.
// the outputs all come from flops loaded on the same edge as the state,
// so the status seen by the caller never lags the internal state.
// run control inputs are sampled only while idle or done; holding
// start high after completion begins a fresh sweep at once.
`timescale 1ns/1ps
module crst_reg_self_test #(
  parameter bit COUPLING = 1'b0
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  // run control from the caller
  input wire logic i_start,
  input wire logic i_supervisor,
  input wire logic i_irq_blocked,
  // register access port of the core
  output crst_pkg::crst_req_t o_core_req,
  input wire crst_pkg::crst_rsp_t i_core_rsp,
  // status
  output logic o_busy,
  output logic o_done,
  output logic o_error,
  output logic o_handler_jump,
  output crst_pkg::crst_phase_t o_fail_phase
);
  import crst_pkg::*;

  // registered sequencer state
  crst_state_t state_q;
  crst_phase_t phase_q;
  logic [3:0] unit_q;
  logic [5:0] step_q;
  logic [31:0] saved_q [NUM_GPR];
  crst_req_t req_q;
  logic busy_q;
  logic done_q;
  logic error_q;
  logic jump_q;
  crst_phase_t fail_phase_q;

  // decoded step and combinational control
  crst_op_t op;
  logic last_step;
  logic last_unit;
  logic last_phase;
  logic all_done;
  logic accept;
  logic ack;
  logic chk_valid;
  logic chk_fail;
  logic advance;
  logic [31:0] req_data;
  // run bookkeeping for the phase order
  logic [4:0] passed_q;
  logic gpr_ok;
  logic issue;

  // sequence decoder
  crst_step_gen #(
    .COUPLING(COUPLING)
  ) u_step (
    .i_phase(phase_q),
    .i_unit(unit_q),
    .i_step(step_q),
    .o_op(op),
    .o_last_step(last_step),
    .o_last_unit(last_unit)
  );

  // read-back compare
  crst_checker u_chk (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_en(i_en),
    .i_valid(chk_valid),
    .i_data(i_core_rsp.rdata),
    .i_exp(op.exp_val),
    .i_mask(op.mask),
    .o_fail(chk_fail)
  );

  // run accepted only with supervisor mode and interrupts blocked
  assign accept = (state_q == ST_IDLE || state_q == ST_DONE) && i_start
                  && i_supervisor && i_irq_blocked;
  assign ack = (state_q == ST_WAIT) && i_core_rsp.ack;
  assign chk_valid = ack && op.cmp;
  assign last_phase = (phase_q == PH_PC);
  assign all_done = last_step && last_unit && last_phase;
  // move on only after a passing compare or a non-compare step
  assign advance = (ack && !op.cmp) || (state_q == ST_CHECK && !chk_fail);
  // a control access is only issued once both general phases passed
  assign gpr_ok = passed_q[PH_GPR1] && passed_q[PH_GPR2];
  assign issue = (state_q == ST_ISSUE) && (phase_q != PH_CTRL || gpr_ok);

  // restore data comes from the saved slot; low accumulator rebuilt
  always_comb begin
    req_data = op.data;
    if (op.restore) begin
      if (op.kind == K_ACC_LO) begin
        req_data = {saved_q[op.slot][ACC_LOW_BITS-1:0], 16'h0000};
      end else begin
        req_data = saved_q[op.slot];
      end
    end
  end

  // main state machine
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
    end else if (i_en) begin
      case (state_q)
        ST_IDLE, ST_DONE: begin
          if (accept) begin
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (issue) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ack) begin
            if (op.cmp) begin
              state_q <= ST_CHECK;
            end else if (all_done) begin
              state_q <= ST_DONE;
            end else begin
              state_q <= ST_ISSUE;
            end
          end
        end
        ST_CHECK: begin
          if (chk_fail) begin
            state_q <= ST_FAIL;
          end else if (all_done) begin
            state_q <= ST_DONE;
          end else begin
            state_q <= ST_ISSUE;
          end
        end
        ST_FAIL: state_q <= ST_FAIL;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // position in the sequence: step, unit, then phase in fixed order
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q <= PH_GPR1;
      unit_q <= 4'h0;
      step_q <= 6'h00;
    end else if (i_en) begin
      if (accept) begin
        phase_q <= PH_GPR1;
        unit_q <= 4'h0;
        step_q <= 6'h00;
      end else if (advance && !all_done) begin
        if (!last_step) begin
          step_q <= step_q + 6'h01;
        end else begin
          step_q <= 6'h00;
          if (!last_unit) begin
            unit_q <= unit_q + 4'h1;
          end else begin
            unit_q <= 4'h0;
            phase_q <= crst_phase_t'(phase_q + 3'd1);
          end
        end
      end
    end
  end

  // phases finished cleanly in the current run, cleared by a new start;
  // a failing phase never sets its bit, since the run stops there
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      passed_q <= 5'h00;
    end else if (i_en) begin
      if (accept) begin
        passed_q <= 5'h00;
      end else if (advance && last_step && last_unit) begin
        passed_q[phase_q] <= 1'b1;
      end
    end
  end

  // request towards the core, held until acknowledged
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_q <= '0;
    end else if (i_en) begin
      if (issue) begin
        req_q.valid <= 1'b1;
        req_q.kind <= op.kind;
        req_q.write <= op.write;
        req_q.index <= op.index;
        req_q.data <= req_data;
      end else if (ack) begin
        req_q.valid <= 1'b0;
      end
    end
  end

  // original register contents, captured by the save reads
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < NUM_GPR; i++) begin
        saved_q[i] <= ZERO_WORD;
      end
    end else if (i_en) begin
      if (ack && op.save) begin
        saved_q[op.slot] <= i_core_rsp.rdata;
      end
    end
  end

  // sticky error, handler jump pulse and failing phase
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      error_q <= 1'b0;
      jump_q <= 1'b0;
      fail_phase_q <= PH_GPR1;
    end else if (i_en) begin
      jump_q <= (state_q == ST_CHECK) && chk_fail;
      if (state_q == ST_CHECK && chk_fail) begin
        error_q <= 1'b1;
        fail_phase_q <= phase_q;
      end
    end
  end

  // busy while running, done only after the last check passes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (i_en) begin
      if (accept) begin
        busy_q <= 1'b1;
        done_q <= 1'b0;
      end else if (advance && all_done) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end else if (state_q == ST_CHECK && chk_fail) begin
        busy_q <= 1'b0;
      end
    end
  end

  // outputs straight from flops
  assign o_core_req = req_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_error = error_q;
  assign o_handler_jump = jump_q;
  assign o_fail_phase = fail_phase_q;

endmodule : crst_reg_self_test

// file: tb/crst_reg_self_test_chk.sv
// assertions on the port behaviour of the register self-test sequencer
`timescale 1ns/1ps
module crst_reg_self_test_chk
  import crst_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  // run control
  input wire logic i_start,
  input wire logic i_supervisor,
  input wire logic i_irq_blocked,
  // core port
  input wire crst_req_t o_core_req,
  input wire crst_rsp_t i_core_rsp,
  // status
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_error,
  input wire logic o_handler_jump,
  input wire crst_phase_t o_fail_phase
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // marks that a non-general access was made in the current run
  logic late_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      late_q <= 1'b0;
    end else if (!o_busy) begin
      late_q <= 1'b0;
    end else if (o_core_req.valid && o_core_req.kind != K_GPR) begin
      late_q <= 1'b1;
    end
  end

  property p_hold;
    o_core_req.valid && !i_core_rsp.ack |=> $stable(o_core_req);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved before answer");
  property p_drop;
    o_core_req.valid && i_core_rsp.ack |=> !o_core_req.valid;
  endproperty
  a_drop: assert property (p_drop) else $error("request not dropped after answer");
  property p_acc_lo;
    o_core_req.valid && o_core_req.kind == K_ACC_LO |-> o_core_req.write;
  endproperty
  a_acc_lo: assert property (p_acc_lo) else $error("low accumulator read");
  property p_acc_mid;
    o_core_req.valid && o_core_req.kind == K_ACC_MID |-> !o_core_req.write;
  endproperty
  a_acc_mid: assert property (p_acc_mid) else $error("middle slice written");
  property p_call;
    o_core_req.valid && o_core_req.kind == K_CALL |-> o_core_req.write && o_core_req.data == PAT_A;
  endproperty
  a_call: assert property (p_call) else $error("bad call parameter");
  property p_order;
    o_core_req.valid && o_core_req.kind == K_GPR |-> !late_q;
  endproperty
  a_order: assert property (p_order) else $error("general access after later phase");
  property p_start_ref;
    !o_busy && i_en && i_start && !(i_supervisor && i_irq_blocked) |=> !o_busy;
  endproperty
  a_start_ref: assert property (p_start_ref) else $error("unsafe start taken");
  property p_err;
    $rose(o_error) |-> o_handler_jump && !o_busy && !o_done;
  endproperty
  a_err: assert property (p_err) else $error("mismatch without handler entry");
  property p_sticky;
    o_error |=> o_error && !o_busy && !o_core_req.valid && $stable(o_fail_phase);
  endproperty
  a_sticky: assert property (p_sticky) else $error("error state left");
  property p_done;
    $rose(o_done) |-> !o_error && !o_busy && $past(o_busy);
  endproperty
  a_done: assert property (p_done) else $error("done without passing run");
endmodule : crst_reg_self_test_chk

// file: tb/crst_core_model.sv
// behavioural processor core answering the sequencer's register port
`timescale 1ns/1ps
module crst_core_model
  import crst_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // register port
  input wire crst_req_t i_req,
  output crst_rsp_t o_rsp,
  // answer delay and injected read fault
  input wire logic [2:0] i_dly,
  input wire logic [2:0] i_fkind,
  input wire logic [3:0] i_fidx,
  input wire logic [31:0] i_fmask
);
  // register file, loaded by the bench while idle
  logic [31:0] gpr [16];
  logic [31:0] ctl [8];
  logic [63:0] acc;
  logic [2:0] wait_q;
  logic ack;
  logic hit;
  logic [31:0] val;

  // answer once the chosen delay has passed; data is garbage outside the answer
  assign ack = i_req.valid && (wait_q >= i_dly);
  assign hit = (i_req.kind == i_fkind) && (i_req.kind > K_CTRL || i_req.index == i_fidx);
  assign o_rsp = {ack, ack ? (hit ? val ^ i_fmask : val) : ~val};

  // wait counter per request
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) wait_q <= 3'h0;
    else wait_q <= ack ? 3'h0 : wait_q + {2'h0, i_req.valid};
  end

  // read side
  always_comb begin
    case (i_req.kind)
      K_GPR: val = gpr[i_req.index];
      K_CTRL: val = ctl[i_req.index[2:0]];
      K_ACC_HI: val = acc[63:32];
      K_ACC_MID: val = acc[47:16];
      K_CALL: val = ~i_req.data;
      default: val = 32'h0000_0000;
    endcase
  end

  // write side
  always @(posedge i_clk) begin
    if (ack && i_req.write) begin
      case (i_req.kind)
        K_GPR: gpr[i_req.index] <= i_req.data;
        K_CTRL: ctl[i_req.index[2:0]] <= i_req.data;
        K_ACC_HI: acc[63:32] <= i_req.data;
        K_ACC_LO: acc[31:0] <= i_req.data;
        default: ;
      endcase
    end
  end
endmodule : crst_core_model

// file: tb/tb_top.sv
// self-checking bench for the register self-test sequencer, both variants
`timescale 1ns/1ps
module tb_top;
  import crst_pkg::*;
  // stimulus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic start = 1'b0;
  logic sup = 1'b1;
  logic irqb = 1'b1;
  logic [2:0] dly = 3'h0;
  logic [2:0] fkind = 3'h7;
  logic [3:0] fidx = 4'h0;
  logic [31:0] fmask = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_0042;
  // observed
  wire crst_req_t req [2];
  wire crst_rsp_t rsp [2];
  wire [1:0] busy, done, err, jump;
  wire crst_phase_t fph [2];
  // bookkeeping
  int error_cnt = 0;
  int tests_run = 0;
  logic [3:0] expq [$];
  logic [15:0] wa [2], wb [2], cw [2];
  logic [1:0] lastc [2];
  int bad [2];
  logic done_d = 1'b0;
  logic [31:0] g0 [16];
  logic [31:0] c0 [8];
  logic [63:0] a0;
  logic [2:0] fk [6] = '{K_GPR, K_GPR, K_CTRL, K_ACC_MID, K_CALL, K_ACC_LO};
  logic [3:0] fi [6] = '{4'hE, 4'hD, 4'h7, 4'h0, 4'h0, 4'h0};
  logic [31:0] fm [6] = '{32'h0000_0001, 32'h8000_0000, 32'h0001_0000,
                          32'h0000_0001, 32'h0000_0001, 32'h0000_FFFF};
  logic [3:0] fe [6] = '{{1'b1, PH_GPR1}, {1'b1, PH_GPR2}, {1'b1, PH_CTRL},
                         {1'b1, PH_ACC}, {1'b1, PH_PC}, 4'h0};

  always #4 clk = ~clk;

  // pairwise design with faulty core, coupling design with clean core
  for (genvar g = 0; g < 2; g++) begin : inst
    crst_reg_self_test #(.COUPLING(g == 1)) uut (.i_clk(clk), .i_rstn(rst_n), .i_en(en),
      .i_start(start), .i_supervisor(sup), .i_irq_blocked(irqb), .o_core_req(req[g]),
      .i_core_rsp(rsp[g]), .o_busy(busy[g]), .o_done(done[g]), .o_error(err[g]),
      .o_handler_jump(jump[g]), .o_fail_phase(fph[g]));
    crst_core_model core (.i_clk(clk), .i_rstn(rst_n), .i_req(req[g]), .o_rsp(rsp[g]),
      .i_dly(dly), .i_fkind(g == 0 ? fkind : 3'h7), .i_fidx(fidx),
      .i_fmask(g == 0 ? fmask : 32'h0000_0000));
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // notes each taken access: phase class order, patterns per register
  task automatic track(input int u, input crst_req_t r);
    logic [1:0] c;
    c = (r.kind == K_GPR) ? 2'h0 : (r.kind == K_CTRL) ? 2'h1 : (r.kind == K_CALL) ? 2'h3 : 2'h2;
    if (c < lastc[u]) bad[u]++;
    lastc[u] = c;
    if (r.write && r.kind == K_GPR && r.data === PAT_A) wa[u][r.index] = 1'b1;
    if (r.write && r.kind == K_GPR && r.data === PAT_B) wb[u][r.index] = 1'b1;
    if (r.write && r.kind == K_CTRL && r.data === (PAT_A & CTRL_MASK[r.index[2:0]]))
      cw[u][r.index[2:0]] = 1'b1;
    if (r.write && r.kind == K_CTRL && r.data === (PAT_B & CTRL_MASK[r.index[2:0]]))
      cw[u][{1'b1, r.index[2:0]}] = 1'b1;
  endtask : track

  always @(posedge clk) begin
    dly <= rnd() % 3'h5;
    for (int u = 0; u < 2; u++) if (req[u].valid && rsp[u].ack) track(u, req[u]);
  end

  // result watcher: handler entry or completion takes the oldest note
  always @(posedge clk) begin
    done_d <= done[0];
    if (jump[0] || (done[0] && !done_d)) begin
      if (expq.size() == 0) cmp({err[0], fph[0]}, 4'hF);
      else cmp({err[0], fph[0]}, expq.pop_front());
    end
  end

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic init_regs();
    for (int i = 0; i < 16; i++) begin
      g0[i] = rnd();
      inst[0].core.gpr[i] = g0[i];
      inst[1].core.gpr[i] = g0[i];
      if (i < 8) c0[i] = rnd();
      if (i < 8) inst[0].core.ctl[i] = c0[i];
      if (i < 8) inst[1].core.ctl[i] = c0[i];
    end
    a0 = {rnd(), rnd()};
    inst[0].core.acc = a0;
    inst[1].core.acc = a0;
  endtask : init_regs

  // one start pulse, then wait for both sequencers to settle
  task automatic run();
    wa = '{16'h0000, 16'h0000};
    wb = '{16'h0000, 16'h0000};
    cw = '{16'h0000, 16'h0000};
    lastc = '{2'h0, 2'h0};
    bad = '{0, 0};
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (int n = 0; n < 5000 && busy !== 2'b00; n++) @(posedge clk);
    cmp(busy, 2'b00);
    repeat (3) @(posedge clk);
  endtask : run

  task automatic check_pass(input int u);
    cmp(bad[u], 0);
    cmp({wa[u], wb[u]}, 32'hFFFF_FFFF);
    cmp(cw[u], 16'hFFFF);
    for (int i = 0; i < 16; i++) begin
      if (u == 0) cmp(inst[0].core.gpr[i], g0[i]);
      else cmp(inst[1].core.gpr[i], g0[i]);
      if (i < 8 && u == 0) cmp(inst[0].core.ctl[i], c0[i]);
      if (i < 8 && u == 1) cmp(inst[1].core.ctl[i], c0[i]);
    end
    if (u == 0) cmp(inst[0].core.acc[63:16], a0[63:16]);
    else cmp(inst[1].core.acc[63:16], a0[63:16]);
  endtask : check_pass

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // watchdog, well past the expected run length
  initial begin
    #480000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    do_reset();
    cmp({busy, done, err, jump, req[0].valid}, 9'h000);
    // starts without safe core state are ignored
    sup <= 1'b0;
    run();
    cmp({busy, done}, 4'h0);
    sup <= 1'b1;
    irqb <= 1'b0;
    run();
    cmp({busy, done}, 4'h0);
    irqb <= 1'b1;
    // a safe start while the enable is low must not be taken
    en <= 1'b0;
    run();
    cmp({busy, done}, 4'h0);
    en <= 1'b1;
    // clean sweeps, the second started from the finished state
    for (int n = 0; n < 2; n++) begin
      init_regs();
      expq.push_back(4'h0);
      run();
      check_pass(0);
      check_pass(1);
      cmp({done, err}, 4'hC);
    end
    // one read fault per phase, plus one in the unread accumulator bits
    for (int f = 0; f < 6; f++) begin
      do_reset();
      init_regs();
      fkind <= fk[f];
      fidx <= fi[f];
      fmask <= fm[f];
      expq.push_back(fe[f]);
      run();
      cmp({done[1], err[1]}, 2'h2);
      cmp({done[0], busy[0]}, {~fe[f][3], 1'b0});
      if (fe[f][3]) run();
      if (fe[f][3]) cmp({busy[0], err[0], req[0].valid}, 3'h2);
      fkind <= 3'h7;
    end
    cmp(expq.size(), 0);
    print_verdict();
  end
endmodule : tb_top

bind crst_reg_self_test crst_reg_self_test_chk chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_en(i_en),
  .i_start(i_start), .i_supervisor(i_supervisor), .i_irq_blocked(i_irq_blocked),
  .o_core_req(o_core_req), .i_core_rsp(i_core_rsp), .o_busy(o_busy), .o_done(o_done),
  .o_error(o_error), .o_handler_jump(o_handler_jump), .o_fail_phase(o_fail_phase));
